// ==== verilog/fcp_ctrl.sv ====
// Purpose : Flash sequencer with protection policy, timing and event status
// Assumes : Register port strobes are single cycle; memory requester holds its request
// Notes   : Array timing runs on a microsecond tick derived from the reload register
`timescale 1ns/100ps
`include "fcp_consts.svh"

// Behaviour
// - Erase sets whole 1-KB unit to ones
// - Program one word, only ones become zeros
// - Protection unit is 2-KB, one bit each
// - Four program and four read enable words
// - Program bit zero refuses any change
// - Read bit zero allows only instruction fetches
// - Policy pair decodes to four access modes
// - Execute-only: no change, fetch-only reads
// - Data read of protected unit gives fault
// - Refused change sets access flag, masked irq
// - Operations timed by cycles-per-microsecond value
// - Reset loads timing for maximum clock
// - Protection bits ship as all ones
// - Bits only clear; power-on restores uncommitted
// - Commit command makes protection permanent
// - Finished program or erase sets done flag
// - Interrupt only for masked-in events
// - Raw status always shows every event
// - Write one clears raw and masked event
// - Data, address, key+write; write bit self-clears
// - Key+commit starts commit; software polls
// - Fetches held off while operation runs
module fcp_ctrl #(
   parameter int AW    = 16,                 // Word address width (256 KB)
   parameter int NREG  = 4                   // Protection word pairs
) (
   // Clock and resets
   input  wire logic              CLOCK_IN,
   input  wire logic              RESETN_IN,
   input  wire logic              POR_N_IN,
   input  wire logic              NV_FACTORY_N_IN,
   // Register port
   input  wire logic [12:0]       REG_ADDR_IN,
   input  wire fcp_pkg::fcp_word_t REG_WDATA_IN,
   input  wire logic              REG_WR_IN,
   input  wire logic              REG_RD_IN,
   output fcp_pkg::fcp_word_t     REG_RDATA_OUT,
   // Memory read port
   input  wire logic              MEM_FETCH_IN,
   input  wire logic              MEM_DATA_RD_IN,
   input  wire logic [AW+1:0]     MEM_ADDR_IN,
   output fcp_pkg::fcp_word_t     MEM_RDATA_OUT,
   output logic                   MEM_ACK_OUT,
   output logic                   MEM_FAULT_OUT,
   // Interrupt
   output logic                   IRQ_OUT
);
   import fcp_pkg::*;

   localparam int UW = AW - 9;               // Protection unit index width

   fcp_arr_if #(.AW(AW)) arr ();
   fcp_array #(.AW(AW)) u_array (.CLOCK_IN(CLOCK_IN), .bus(arr));

   // ****************************************************************
   // State
   // ****************************************************************
   logic              rst;                   // Control reset
   fcp_word_t         addr_q;                // Target address
   fcp_word_t         data_q;                // Write data
   fcp_word_t         re_q [NREG];           // Working read enables
   fcp_word_t         pe_q [NREG];           // Working program enables
   fcp_word_t         nv_re_q [NREG];        // Committed read enables
   fcp_word_t         nv_pe_q [NREG];        // Committed program enables
   logic [7:0]        usec_q;                // Cycles per microsecond minus one
   logic [7:0]        tick_cnt_q;            // Divider
   logic              tick_q;                // Microsecond enable pulse
   logic [15:0]       us_left_q;             // Remaining wait
   logic [AW-1:0]     word_q;                // Erase walk pointer
   logic [AW-1:0]     word_end_q;            // Last word of walk
   fcp_state_e        state_q;
   fcp_op_e           op_q;
   logic [1:0]        raw_q;                 // Raw event status
   logic [1:0]        mask_q;                // Event mask
   logic              busy;
   logic              ctl_wr;                // Keyed control write
   logic              chg_req;               // Program or erase request
   logic              chg_ok;                // Target unit programmable
   logic              acc_evt;               // Refused change
   logic              done_evt;              // Program or erase finished
   logic [UW-1:0]     tgt_unit;
   logic [UW-1:0]     rd_unit;
   logic              all_pe;
   logic              rd_req;
   logic              rd_blocked;
   fcp_word_t         rdata_q;
   logic              ack_q;
   logic              fault_q;
   logic              irq_q;

   assign rst  = !RESETN_IN || !POR_N_IN;
   assign busy = state_q != FCP_IDLE;

   // ****************************************************************
   // Policy lookup
   // ****************************************************************
   // Unit index is byte address over 2 KB; word and bit follow
   assign tgt_unit = addr_q[AW+1:11];
   assign rd_unit  = MEM_ADDR_IN[AW+1:11];
   assign chg_ok   = pe_q[tgt_unit[UW-1:5]][tgt_unit[4:0]];
   assign all_pe   = &{pe_q[0], pe_q[1], pe_q[2], pe_q[3]};
   assign ctl_wr   = REG_WR_IN && REG_ADDR_IN == `FCP_OFF_CTL && !busy &&
                     REG_WDATA_IN[31:16] == `FCP_KEY;
   assign chg_req  = ctl_wr && |REG_WDATA_IN[`FCP_CTL_MERASE:`FCP_CTL_WRITE];
   // Mass erase needs every unit open
   assign acc_evt  = chg_req && (REG_WDATA_IN[`FCP_CTL_MERASE] ? !all_pe : !chg_ok);
   assign done_evt = state_q == FCP_FINISH && op_q != FCP_OP_COMMIT;
   // Fetch path ignores the read policy; data reads obey it
   assign rd_req     = !busy && (MEM_FETCH_IN || MEM_DATA_RD_IN);
   assign rd_blocked = !MEM_FETCH_IN &&
                       !re_q[rd_unit[UW-1:5]][rd_unit[4:0]];

   // ****************************************************************
   // Software registers
   // ****************************************************************
   // Address, data, mask and timing reload
   always_ff @(posedge CLOCK_IN) begin
      if (rst) begin
         addr_q <= '0;
         data_q <= '0;
         mask_q <= '0;
         usec_q <= `FCP_USEC_RST;
      end else if (REG_WR_IN) begin
         unique case (REG_ADDR_IN)
            `FCP_OFF_ADDR:  addr_q <= REG_WDATA_IN;
            `FCP_OFF_DATA:  data_q <= REG_WDATA_IN;
            `FCP_OFF_IMASK: mask_q <= REG_WDATA_IN[1:0];
            `FCP_OFF_USEC:  usec_q <= REG_WDATA_IN[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Protection words
   // ****************************************************************
   // Working copies reload from the committed store only on power-on
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_prot
         always_ff @(posedge CLOCK_IN) begin
            if (!POR_N_IN) begin
               re_q[g] <= nv_re_q[g];
               pe_q[g] <= nv_pe_q[g];
            end else if (REG_WR_IN) begin
               // Writes can only clear bits
               if (REG_ADDR_IN == `FCP_OFF_RE_BASE + 13'(4*g) ||
                   (g == 0 && REG_ADDR_IN == `FCP_OFF_RE0_ALT)) begin
                  re_q[g] <= re_q[g] & REG_WDATA_IN;
               end
               if (REG_ADDR_IN == `FCP_OFF_PE_BASE + 13'(4*g) ||
                   (g == 0 && REG_ADDR_IN == `FCP_OFF_PE0_ALT)) begin
                  pe_q[g] <= pe_q[g] & REG_WDATA_IN;
               end
            end
         end

         // Committed store; only the factory line restores it
         always_ff @(posedge CLOCK_IN) begin
            if (!NV_FACTORY_N_IN) begin
               nv_re_q[g] <= `FCP_PROT_RST;
               nv_pe_q[g] <= `FCP_PROT_RST;
            end else if (state_q == FCP_FINISH && op_q == FCP_OP_COMMIT &&
                         addr_q[31:3] == '0 && addr_q[2:1] == 2'(g)) begin
               if (addr_q[0]) begin
                  nv_pe_q[g] <= pe_q[g];
               end else begin
                  nv_re_q[g] <= re_q[g];
               end
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Microsecond tick
   // ****************************************************************
   // Reload value is cycles per microsecond minus one
   always_ff @(posedge CLOCK_IN) begin
      if (rst) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == 8'h00) begin
         tick_cnt_q <= usec_q;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q - 8'h01;
         tick_q     <= 1'b0;
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   // Refused commands never leave idle, so the control bit reads clear at once
   always_ff @(posedge CLOCK_IN) begin
      if (rst) begin
         state_q    <= FCP_IDLE;
         op_q       <= FCP_OP_PROG;
         us_left_q  <= '0;
         word_q     <= '0;
         word_end_q <= '0;
      end else begin
         unique case (state_q)
            FCP_IDLE: begin
               if (ctl_wr && !acc_evt) begin
                  state_q <= FCP_WAIT;
                  if (REG_WDATA_IN[`FCP_CTL_WRITE]) begin
                     op_q      <= FCP_OP_PROG;
                     us_left_q <= `FCP_PROG_US;
                  end else if (REG_WDATA_IN[`FCP_CTL_ERASE]) begin
                     op_q       <= FCP_OP_ERASE;
                     us_left_q  <= `FCP_ERASE_US;
                     word_q     <= {addr_q[AW+1:10], 8'h00};
                     word_end_q <= {addr_q[AW+1:10], 8'hff};
                  end else if (REG_WDATA_IN[`FCP_CTL_MERASE]) begin
                     op_q       <= FCP_OP_MERASE;
                     us_left_q  <= `FCP_ERASE_US;
                     word_q     <= '0;
                     word_end_q <= '1;
                  end else if (REG_WDATA_IN[`FCP_CTL_COMMIT]) begin
                     op_q      <= FCP_OP_COMMIT;
                     us_left_q <= `FCP_COMMIT_US;
                  end else begin
                     state_q <= FCP_IDLE;
                  end
               end
            end
            FCP_WAIT: begin
               if (tick_q) begin
                  if (us_left_q == 16'd1) begin
                     state_q <= (op_q == FCP_OP_ERASE || op_q == FCP_OP_MERASE) ?
                                FCP_ERASE : FCP_FINISH;
                  end
                  us_left_q <= us_left_q - 16'd1;
               end
            end
            FCP_ERASE: begin
               word_q <= word_q + 1'b1;
               if (word_q == word_end_q) begin
                  state_q <= FCP_FINISH;
               end
            end
            FCP_FINISH: state_q <= FCP_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Array port
   // ****************************************************************
   // Program lands in the finish cycle, erase walks one word per cycle
   always_comb begin
      arr.prog  = state_q == FCP_FINISH && op_q == FCP_OP_PROG;
      arr.erase = state_q == FCP_ERASE;
      arr.rd    = rd_req;
      arr.wdata = data_q;
      if (state_q == FCP_ERASE) begin
         arr.addr = word_q;
      end else if (busy) begin
         arr.addr = addr_q[AW+1:2];
      end else begin
         arr.addr = MEM_ADDR_IN[AW+1:2];
      end
   end

   // ****************************************************************
   // Memory read answers
   // ****************************************************************
   // Held-off requests get no answer; the requester keeps asking
   always_ff @(posedge CLOCK_IN) begin
      if (rst) begin
         ack_q   <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         ack_q   <= rd_req && !rd_blocked;
         fault_q <= rd_req && rd_blocked;
      end
   end

   // ****************************************************************
   // Event status
   // ****************************************************************
   // A new event beats a clear in the same cycle
   always_ff @(posedge CLOCK_IN) begin
      if (rst) begin
         raw_q <= '0;
         irq_q <= 1'b0;
      end else begin
         raw_q[`FCP_IRQ_ACCESS] <= acc_evt ||
            (raw_q[`FCP_IRQ_ACCESS] && !(REG_WR_IN && REG_ADDR_IN == `FCP_OFF_MISC &&
                                         REG_WDATA_IN[`FCP_IRQ_ACCESS]));
         raw_q[`FCP_IRQ_PROG] <= done_evt ||
            (raw_q[`FCP_IRQ_PROG] && !(REG_WR_IN && REG_ADDR_IN == `FCP_OFF_MISC &&
                                       REG_WDATA_IN[`FCP_IRQ_PROG]));
         irq_q <= |(raw_q & mask_q);
      end
   end

   // ****************************************************************
   // Register read
   // ****************************************************************
   always_ff @(posedge CLOCK_IN) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (REG_RD_IN) begin
         rdata_q <= '0;
         unique case (REG_ADDR_IN)
            `FCP_OFF_ADDR:    rdata_q <= addr_q;
            `FCP_OFF_DATA:    rdata_q <= data_q;
            `FCP_OFF_CTL:     rdata_q <= {28'h0, busy && op_q == FCP_OP_COMMIT,
                                          busy && op_q == FCP_OP_MERASE,
                                          busy && op_q == FCP_OP_ERASE,
                                          busy && op_q == FCP_OP_PROG};
            `FCP_OFF_RIS:     rdata_q <= {30'h0, raw_q};
            `FCP_OFF_IMASK:   rdata_q <= {30'h0, mask_q};
            `FCP_OFF_MISC:    rdata_q <= {30'h0, raw_q & mask_q};
            `FCP_OFF_USEC:    rdata_q <= {24'h0, usec_q};
            `FCP_OFF_RE0_ALT: rdata_q <= re_q[0];
            `FCP_OFF_PE0_ALT: rdata_q <= pe_q[0];
            default: begin
               for (int i = 0; i < NREG; i++) begin
                  if (REG_ADDR_IN == `FCP_OFF_RE_BASE + 13'(4*i)) rdata_q <= re_q[i];
                  if (REG_ADDR_IN == `FCP_OFF_PE_BASE + 13'(4*i)) rdata_q <= pe_q[i];
               end
            end
         endcase
      end
   end

   assign REG_RDATA_OUT = rdata_q;
   assign MEM_RDATA_OUT = arr.rdata;
   assign MEM_ACK_OUT   = ack_q;
   assign MEM_FAULT_OUT = fault_q;
   assign IRQ_OUT       = irq_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (rst);

   sequence s_refused_chg;
      ctl_wr && REG_WDATA_IN[`FCP_CTL_WRITE] && !chg_ok;
   endsequence
   sequence s_blocked_rd;
      !busy && MEM_DATA_RD_IN && !MEM_FETCH_IN && rd_blocked;
   endsequence

   a_refused_flag: assert property (s_refused_chg |=> raw_q[`FCP_IRQ_ACCESS] && !busy)
      else $error("refused program did not flag access");
   a_read_fault: assert property (s_blocked_rd |=> MEM_FAULT_OUT && !MEM_ACK_OUT)
      else $error("protected data read not faulted");
   a_fetch_served: assert property (!busy && MEM_FETCH_IN |=> MEM_ACK_OUT && !MEM_FAULT_OUT)
      else $error("fetch not answered");
   a_busy_holdoff: assert property (busy |=> !MEM_ACK_OUT && !MEM_FAULT_OUT)
      else $error("read answered during operation");
   a_done_flag: assert property (done_evt |=> raw_q[`FCP_IRQ_PROG] && !busy)
      else $error("finish did not set done flag");
   a_irq_masked: assert property (##1 IRQ_OUT == |($past(raw_q) & $past(mask_q)))
      else $error("interrupt output mismatch");
   a_w1c_clear: assert property (REG_WR_IN && REG_ADDR_IN == `FCP_OFF_MISC &&
      REG_WDATA_IN[`FCP_IRQ_PROG] && !done_evt |=> !raw_q[`FCP_IRQ_PROG])
      else $error("write one did not clear");
   a_prot_clear_only: assert property (POR_N_IN && $past(POR_N_IN) |->
      (pe_q[0] & ~$past(pe_q[0])) == '0 && (re_q[0] & ~$past(re_q[0])) == '0)
      else $error("protection bit rose without power-on");
   a_usec_reset: assert property ($fell(rst) |-> usec_q == `FCP_USEC_RST)
      else $error("reload value wrong after reset");
   a_prog_lands: assert property (arr.prog |-> op_q == FCP_OP_PROG ##1 !busy)
      else $error("program strobe outside finish");
endmodule

// ==== verilog/fcp_consts.svh ====
// Purpose : Offsets, field positions, reset values and timing counts of the flash controller
// Assumes : Included by bare name; definitions only
// Notes   : Offsets with bit 12 set sit in the system control window of the register port
`ifndef FCP_CONSTS_SVH
`define FCP_CONSTS_SVH

// ****************************************************************
// Register offsets on the 13-bit register port
// ****************************************************************
`define FCP_OFF_ADDR    13'h0000
`define FCP_OFF_DATA    13'h0004
`define FCP_OFF_CTL     13'h0008
`define FCP_OFF_RIS     13'h000c
`define FCP_OFF_IMASK   13'h0010
`define FCP_OFF_MISC    13'h0014
`define FCP_OFF_RE0_ALT 13'h1130
`define FCP_OFF_PE0_ALT 13'h1134
`define FCP_OFF_USEC    13'h1140
`define FCP_OFF_RE_BASE 13'h1200
`define FCP_OFF_PE_BASE 13'h1400

// ****************************************************************
// Control word fields
// ****************************************************************
`define FCP_KEY        16'ha442
`define FCP_CTL_WRITE  0
`define FCP_CTL_ERASE  1
`define FCP_CTL_MERASE 2
`define FCP_CTL_COMMIT 3

// ****************************************************************
// Interrupt status bit positions
// ****************************************************************
`define FCP_IRQ_ACCESS 0
`define FCP_IRQ_PROG   1

// ****************************************************************
// Reset values and timing (counts are in microsecond ticks)
// ****************************************************************
`define FCP_USEC_RST   8'h31
`define FCP_PROT_RST   32'hffffffff
`define FCP_PROG_US    16'd20
`define FCP_ERASE_US   16'd20
`define FCP_COMMIT_US  16'd20

`endif

// ==== verilog/fcp_pkg.sv ====
// Purpose : Types shared by the flash controller files
// Assumes : Nothing
// Notes   : Numbers live in fcp_consts.svh
package fcp_pkg;
   typedef logic [31:0] fcp_word_t;          // Bus and array word
   typedef enum {FCP_IDLE, FCP_WAIT, FCP_ERASE, FCP_FINISH} fcp_state_e;
   typedef enum {FCP_OP_PROG, FCP_OP_ERASE, FCP_OP_MERASE, FCP_OP_COMMIT} fcp_op_e;
endpackage

// ==== verilog/fcp_arr_if.sv ====
// Purpose : Port bundle between the sequencer and the flash array
// Assumes : One clock
// Notes   : prog ANDs data in, erase writes all ones
`timescale 1ns/100ps
interface fcp_arr_if #(parameter int AW = 16);
   logic          rd;                       // Read strobe
   logic          prog;                     // Program strobe
   logic          erase;                    // Word erase strobe
   logic [AW-1:0] addr;                     // Word address
   logic [31:0]   wdata;                    // Program data
   logic [31:0]   rdata;                    // Read data, one cycle after rd
   modport ctl (output rd, prog, erase, addr, wdata, input rdata);
   modport arr (input rd, prog, erase, addr, wdata, output rdata);
endinterface

// ==== verilog/fcp_array.sv ====
// Purpose : Flash cell array, one word per entry
// Assumes : Strobes are exclusive
// Notes   : Contents have no reset, as real cells keep their charge
`timescale 1ns/100ps
module fcp_array #(
   parameter int AW = 16
) (
   input wire logic CLOCK_IN,
   fcp_arr_if.arr   bus
);
   import fcp_pkg::*;

   fcp_word_t mem [0:(1<<AW)-1];            // Cell storage
   fcp_word_t rdata_q;                      // Registered read word

   // ****************************************************************
   // Cell update
   // ****************************************************************
   // Programming can only pull ones down to zero
   always_ff @(posedge CLOCK_IN) begin
      if (bus.prog) begin
         mem[bus.addr] <= mem[bus.addr] & bus.wdata;
      end else if (bus.erase) begin
         mem[bus.addr] <= `FCP_PROT_RST;
      end
   end

   // Read port, one cycle latency
   always_ff @(posedge CLOCK_IN) begin
      if (bus.rd) begin
         rdata_q <= mem[bus.addr];
      end
   end

   assign bus.rdata = rdata_q;
endmodule

// ==== verif/fcp_cpu_model.sv ====
// Purpose: Processor side requester of flash words
// Assumes: One request at a time, held until answered
// Notes  : Idle address wanders so a stale value never passes
`timescale 1ns/100ps
module fcp_cpu_model (
   // Command from the bench
   input  wire logic        clk_in,
   input  wire logic        go_in,
   input  wire logic        fetch_in,
   input  wire logic [17:0] addr_in,
   // Controller side
   input  wire logic        ack_in,
   input  wire logic        fault_in,
   output logic             fetch_out,
   output logic             data_rd_out,
   output logic [17:0]      addr_out
);
   initial begin
      fetch_out = 1'b0;
      data_rd_out = 1'b0;
      addr_out = 18'h00000;
   end
   // Hold the request until an answer is sampled (a busy array gives none)
   always @(posedge clk_in) begin
      if (go_in) begin
         fetch_out <= fetch_in;
         data_rd_out <= !fetch_in;
         addr_out <= addr_in;
      end else if (ack_in || fault_in) begin
         fetch_out <= 1'b0;
         data_rd_out <= 1'b0;
      end else if (!fetch_out && !data_rd_out) begin
         addr_out <= ~addr_out;
      end
   end
endmodule

// ==== verif/fcp_ctrl_tb_top.sv ====
// Purpose: Self-checking bench of the flash controller
// Assumes: Expected notes queued by drivers, popped by a watcher
// Notes  : Timing reload set to 0 to keep erases short
`timescale 1ns/100ps
`include "fcp_consts.svh"
module fcp_ctrl_tb_top;
   import fcp_pkg::*;
   logic clk = 0, rst_n = 0, por_n = 0, fac_n = 0, wr = 0, rd = 0, go = 0, fe = 0, rd_d = 0;
   logic [12:0] ra = 13'h0000;
   logic [17:0] ma = 18'h00000, mad;
   fcp_word_t wd = 32'h0, rdat, mrd, last, d, d2;
   logic ack, flt, irq, mf, mr;
   logic [32:0] rq[$], mq[$], e;
   int fails = 0, checks_done = 0, seed = 32'hb3f7a088, i;
   always #20 clk = ~clk;
   fcp_cpu_model cpu (.clk_in(clk), .go_in(go), .fetch_in(fe), .addr_in(ma), .ack_in(ack),
      .fault_in(flt), .fetch_out(mf), .data_rd_out(mr), .addr_out(mad));
   fcp_ctrl dut (.CLOCK_IN(clk), .RESETN_IN(rst_n), .POR_N_IN(por_n), .NV_FACTORY_N_IN(fac_n),
      .REG_ADDR_IN(ra), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat),
      .MEM_FETCH_IN(mf), .MEM_DATA_RD_IN(mr), .MEM_ADDR_IN(mad), .MEM_RDATA_OUT(mrd),
      .MEM_ACK_OUT(ack), .MEM_FAULT_OUT(flt), .IRQ_OUT(irq));
   task automatic cmp(input logic [32:0] g, input logic [32:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic test_done();
      if (fails == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Watcher: pops the oldest note whenever a result shows
   always @(posedge clk) begin
      rd_d <= rd;
      if (rd_d) begin
         last <= rdat;
         // Bit 32 of a note marks a read whose value is checked
         if (rq.size()) begin
            e = rq.pop_front();
            if (e[32]) cmp({1'b1, rdat}, e);
         end
      end
      if ((ack || flt) && mq.size()) cmp({flt, ack ? mrd : 32'h0}, mq.pop_front());
   end
   task automatic wreg(input logic [12:0] a, input fcp_word_t v);
      @(posedge clk);
      ra <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [12:0] a, input logic [32:0] e);
      @(posedge clk);
      ra <= a;
      rd <= 1'b1;
      rq.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic poll(input int b);
      int n;
      for (n = 0; n < 3000; n++) begin
         rreg(`FCP_OFF_CTL, 33'h0);
         repeat (2) @(posedge clk);
         if (last[b] === 1'b0) break;
      end
      if (n == 3000) begin
         fails++;
         test_done();
      end
   endtask
   task automatic mem(input logic [17:0] a, input logic f, input logic [32:0] e);
      int n;
      mq.push_back(e);
      @(posedge clk);
      go <= 1'b1;
      ma <= a;
      fe <= f;
      @(posedge clk);
      go <= 1'b0;
      for (n = 0; n < 500 && mq.size(); n++) @(posedge clk);
      if (n == 500) begin
         fails++;
         test_done();
      end
      repeat (3) @(posedge clk);
   endtask
   initial begin
      repeat (19) @(posedge clk);
      fac_n <= 1'b1;
      @(posedge clk);
      {por_n, rst_n} <= 2'b11;
      rreg(`FCP_OFF_USEC, 33'h1_00000031);
      for (i = 0; i < 8; i++) rreg(`FCP_OFF_RE_BASE + 13'(i[0] * 512 + i[2:1] * 4), 33'h1_ffffffff);
      rreg(13'h0ffc, 33'h1_00000000);
      wreg(`FCP_OFF_USEC, 32'h0);
      wreg(`FCP_OFF_ADDR, 32'h400);
      wreg(`FCP_OFF_CTL, 32'ha4420002);
      poll(1);
      mem(18'h7fc, 1'b1, 33'h0_ffffffff);
      rreg(`FCP_OFF_RIS, 33'h1_00000002);
      d = $random(seed);
      d2 = $random(seed);
      for (i = 0; i < 2; i++) begin
         wreg(`FCP_OFF_DATA, i ? d2 : d);
         wreg(`FCP_OFF_ADDR, 32'h404);
         wreg(`FCP_OFF_CTL, 32'ha4420001);
         poll(0);
      end
      mem(18'h404, 1'b0, {1'b0, d & d2});
      wreg(`FCP_OFF_MISC, 32'h3);
      rreg(`FCP_OFF_RIS, 33'h1_00000000);
      wreg(`FCP_OFF_PE_BASE, 32'hfffffffe);
      wreg(`FCP_OFF_IMASK, 32'h1);
      wreg(`FCP_OFF_DATA, 32'h0);
      wreg(`FCP_OFF_CTL, 32'ha4420001);
      poll(0);
      rreg(`FCP_OFF_RIS, 33'h1_00000001);
      @(negedge clk) cmp({32'h0, irq}, 33'h0_00000001);
      mem(18'h404, 1'b0, {1'b0, d & d2});
      wreg(`FCP_OFF_MISC, 32'h1);
      rreg(`FCP_OFF_MISC, 33'h1_00000000);
      wreg(`FCP_OFF_PE0_ALT, 32'hffffffff);
      rreg(`FCP_OFF_PE_BASE, 33'h1_fffffffe);
      wreg(`FCP_OFF_RE_BASE, 32'hfffffffe);
      mem(18'h404, 1'b0, 33'h1_00000000);
      mem(18'h404, 1'b1, {1'b0, d & d2});
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rreg(`FCP_OFF_RE_BASE, 33'h1_fffffffe);
      wreg(`FCP_OFF_ADDR, 32'h1);
      wreg(`FCP_OFF_CTL, 32'ha4420008);
      poll(3);
      por_n <= 1'b0;
      repeat (2) @(posedge clk);
      por_n <= 1'b1;
      rreg(`FCP_OFF_RE0_ALT, 33'h1_ffffffff);
      rreg(`FCP_OFF_PE_BASE, 33'h1_fffffffe);
      repeat (4) @(posedge clk);
      test_done();
   end
endmodule
